// [rtl/adc_seq_pkg.sv]
// Shared constants for the converter sequencer: register map, fields, timing.
package adc_seq_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] RES_HIGH_OFFS = 8'h04;
  localparam logic [7:0] RES_LOW_OFFS = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFFS = 8'h0C;
  localparam logic [7:0] IRQ_CLEAR_OFFS = 8'h10;
  localparam logic [7:0] IRQ_ENABLE_OFFS = 8'h14;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_START_BIT = 3;
  localparam int CTRL_EOC_BIT = 4;
  localparam int CTRL_SETUP_OK_BIT = 5;
  localparam int IRQ_EOC_BIT = 0;

  // ****************************************************************
  // Reset values and answers
  // ****************************************************************
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int RES_BITS = 10;
  localparam int SAMPLE_PERIODS = 1;
  localparam int CONV_PERIODS = SAMPLE_PERIODS + RES_BITS;
  localparam int SYS_CLK_KHZ = 125000;
  localparam int ADC_CLK_KHZ = 700;
  localparam int ADC_DIV = SYS_CLK_KHZ / ADC_CLK_KHZ;
  localparam int SETUP_NS = 4000;
  localparam int SYS_PERIOD_NS = 8;
  localparam int SETUP_CYCLES = (SETUP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0001,
    SEQ_SAMPLE = 4'b0010,
    SEQ_CONVERT = 4'b0100,
    SEQ_DONE = 4'b1000
  } seq_state_t;

endpackage

// [rtl/adc_clk_tick.sv]
// Converter clock tick generator dividing the system clock down to the converter rate.
`timescale 1ns/1ps
module adc_clk_tick
  import adc_seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  output logic tick
);

  logic [7:0] count_q;

  // Held at zero while the converter is off so the first period after enable is whole.
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count_q <= 8'h00;
    end else if (count_q == 8'(ADC_DIV - 1)) begin
      count_q <= 8'h00;
    end else begin
      count_q <= count_q + 8'h01;
    end
  end

  assign tick = run && (count_q == 8'(ADC_DIV - 1));

endmodule // adc_clk_tick

// [rtl/conv_sequencer.sv]
// Successive-approximation sequencer: one sample period then ten bit decisions.
`timescale 1ns/1ps
module conv_sequencer
  import adc_seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic start_req,
  input wire logic cmp_in,
  output logic busy,
  output logic done,
  output logic [9:0] result,
  output logic sample_q,
  output logic [9:0] trial_q
);

  seq_state_t state_q;
  logic [3:0] bit_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= SEQ_IDLE;
      bit_q <= 4'h0;
      sample_q <= 1'b0;
      trial_q <= 10'h000;
    end else begin
      case (state_q)
        SEQ_IDLE: begin
          if (start_req && tick) begin
            state_q <= SEQ_SAMPLE;
            sample_q <= 1'b1;
            trial_q <= 10'h000;
          end
        end
        SEQ_SAMPLE: begin
          if (tick) begin
            state_q <= SEQ_CONVERT;
            sample_q <= 1'b0;
            bit_q <= 4'(RES_BITS - 1);
            trial_q <= 10'h200;
          end
        end
        SEQ_CONVERT: begin
          if (tick) begin
            // Keep the trial bit when the input is at or above the trial level.
            trial_q[bit_q] <= cmp_in;
            if (bit_q == 4'h0) begin
              state_q <= SEQ_DONE;
            end else begin
              trial_q[bit_q - 4'h1] <= 1'b1;
              bit_q <= bit_q - 4'h1;
            end
          end
        end
        SEQ_DONE: begin
          state_q <= SEQ_IDLE;
        end
        default: begin
          state_q <= SEQ_IDLE;
        end
      endcase
    end
  end

  assign busy = (state_q != SEQ_IDLE);
  assign done = (state_q == SEQ_DONE);
  assign result = trial_q;

endmodule // conv_sequencer

// [rtl/adc_conversion_sequencer.sv]
// Converter control block: AXI4-Lite registers, start handling, result and interrupt.
// What this block does
// - Setting the start bit begins exactly one conversion.
// - Hardware clears the start bit once that conversion has finished.
// - The end-of-conversion flag sets as the result lands in the result registers.
// - The flag stays set until software clears it; hardware never clears it.
// - An interrupt is raised while the flag is set and the interrupt enable is set.
// - A conversion lasts eleven converter clocks: one sample, ten bit decisions.
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmp_in,
  output logic sample_hold,
  output logic [9:0] dac_trial,
  output logic irq
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    logic [2:0] sel;
    sel = 3'h7;
    case (addr)
      CTRL_OFFS: sel = 3'h0;
      RES_HIGH_OFFS: sel = 3'h1;
      RES_LOW_OFFS: sel = 3'h2;
      IRQ_STATUS_OFFS: sel = 3'h3;
      IRQ_CLEAR_OFFS: sel = 3'h4;
      IRQ_ENABLE_OFFS: sel = 3'h5;
      default: sel = 3'h7;
    endcase
    return sel;
  endfunction

  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic [2:0] wr_sel;
  logic wr_lane0;

  logic enable_q;
  logic start_q;
  logic eoc_q;
  logic irq_en_q;
  logic [9:0] result_q;
  logic [9:0] setup_cnt_q;
  logic setup_ok;
  logic cmp_meta_q;
  logic cmp_sync_q;
  logic tick;
  logic seq_busy;
  logic seq_done;
  logic [9:0] seq_result;
  logic eoc_clear;

  // ****************************************************************
  // Write channel
  // ****************************************************************
  // Address and data are latched independently so either may arrive first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= ZERO_WORD;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  // Both readies stay low while a response waits: one write in flight at a time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_sel = reg_sel(awaddr_q);
  assign wr_lane0 = wr_fire && wstrb_q[0];

  // An unmapped address still completes the handshake, with an error answer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_sel == 3'h7) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Enable may drop mid-conversion; the sequencer still runs that conversion out.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= 1'b0;
    end else if (wr_lane0 && wr_sel == 3'h0) begin
      enable_q <= wdata_q[CTRL_ENABLE_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_q <= 1'b0;
    end else if (wr_lane0 && wr_sel == 3'h5) begin
      irq_en_q <= wdata_q[IRQ_EOC_BIT];
    end
  end

  // Start is only accepted with the converter enabled; a start while off is dropped.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= 1'b0;
    end else if (seq_done) begin
      start_q <= 1'b0;
    end else if (wr_lane0 && wr_sel == 3'h0 && wdata_q[CTRL_START_BIT] && enable_q) begin
      start_q <= 1'b1;
    end else if (!enable_q && !seq_busy) begin
      start_q <= 1'b0;
    end
  end

  // Counts the setup time after enable so software can poll readiness.
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_q) begin
      setup_cnt_q <= 10'h000;
    end else if (!setup_ok) begin
      setup_cnt_q <= setup_cnt_q + 10'h001;
    end
  end

  assign setup_ok = (setup_cnt_q == 10'(SETUP_CYCLES));

  // ****************************************************************
  // Conversion engine
  // ****************************************************************
  // The comparator is asynchronous to this clock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end else begin
      cmp_meta_q <= cmp_in;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  // The divider keeps running through a conversion even if enable drops,
  // so a started conversion always completes cleanly.
  adc_clk_tick u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(enable_q || seq_busy),
    .tick(tick)
  );

  conv_sequencer u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .start_req(start_q),
    .cmp_in(cmp_sync_q),
    .busy(seq_busy),
    .done(seq_done),
    .result(seq_result),
    .sample_q(sample_hold),
    .trial_q(dac_trial)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= 10'h000;
    end else if (seq_done) begin
      result_q <= seq_result;
    end
  end

  // Clear is write-one, so a zero written to this offset leaves the flag alone.
  assign eoc_clear = wr_lane0 && wr_sel == 3'h4 && wdata_q[IRQ_EOC_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eoc_q <= 1'b0;
    end else if (seq_done) begin
      eoc_q <= 1'b1;
    end else if (eoc_clear) begin
      eoc_q <= 1'b0;
    end
  end

  // The level follows the flag in the same cycle and the enable one cycle late, yet comes straight from a flip-flop.
  // gated interrupt level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (eoc_q || seq_done) && irq_en_q && !(eoc_clear && !seq_done);
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  function automatic logic [31:0] read_word(input logic [2:0] sel);
    logic [31:0] w;
    w = ZERO_WORD;
    case (sel)
      3'h0: begin
        w[CTRL_ENABLE_BIT] = enable_q;
        w[CTRL_START_BIT] = start_q;
        w[CTRL_EOC_BIT] = eoc_q;
        w[CTRL_SETUP_OK_BIT] = setup_ok;
      end
      3'h1: w[7:0] = result_q[9:2];
      3'h2: w[1:0] = result_q[1:0];
      3'h3: w[IRQ_EOC_BIT] = eoc_q;
      3'h5: w[IRQ_EOC_BIT] = irq_en_q;
      default: w = ZERO_WORD;
    endcase
    return w;
  endfunction

  // Address ready drops while a read answer waits, so only one read is in flight.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  // Read data is captured with the address, so a later flag change cannot tear it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= ZERO_WORD;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_word(reg_sel(s_axi_araddr));
      s_axi_rresp <= (reg_sel(s_axi_araddr) == 3'h7) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // adc_conversion_sequencer

// [tb/analog_model.sv]
// Analog front end model: holds the sampled level and compares it to the trial code.
`timescale 1ns/1ps
module analog_model (
  input wire logic aclk,
  input wire logic sample_hold,
  input wire logic [9:0] dac_trial,
  input wire logic [9:0] vin,
  output logic cmp_in
);
  logic [9:0] held_q = 10'h000;
  always_ff @(posedge aclk) begin
    if (sample_hold) begin
      held_q <= vin;
    end
  end
  // Comparing against the held level keeps input changes out of a running conversion.
  assign cmp_in = (held_q >= dac_trial);
endmodule // analog_model

// [tb/adc_seq_properties.sv]
// Port-level checks of the converter sequencer.
`timescale 1ns/1ps
module adc_seq_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_hold,
  input wire logic [9:0] dac_trial,
  input wire logic irq
);
  // ***
  // Cycles since the sample period ended
  // ***
  logic [11:0] since_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_q <= 12'hFFF;
    end else if ($fell(sample_hold)) begin
      since_q <= 12'h000;
    end else if (since_q != 12'hFFF) begin
      since_q <= since_q + 12'h001;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_sample;
    $rose(sample_hold) ##1 sample_hold [*8];
  endsequence
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  chk_sample_len: assert property (s_sample |-> ##[166:172] $fell(sample_hold))
    else $error("sample period length wrong");
  chk_trial_msb: assert property ($fell(sample_hold) |-> ##[0:2] dac_trial == 10'h200)
    else $error("first trial is not the top bit");
  chk_no_restart: assert property ($rose(sample_hold) |-> since_q >= 12'h6F4)
    else $error("conversion restarted early");
  chk_irq_sticky: assert property (irq && s_axi_awready |=> irq)
    else $error("interrupt dropped without a write");
  chk_b_answer: assert property (s_both_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
endmodule // adc_seq_properties
bind adc_conversion_sequencer adc_seq_properties u_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .sample_hold,
  .dac_trial, .irq);

// [tb/adc_conversion_sequencer_bench.sv]
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ps
module adc_conversion_sequencer_bench
  import adc_seq_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [9:0] vin = 10'h000;
  logic awready, wready, bvalid, arready, rvalid, irq, sample_hold, cmp_in;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d, seed;
  logic [9:0] dac_trial, v;
  int cyc = 0;
  int t0, err_count, n_tests;
  adc_conversion_sequencer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmp_in(cmp_in),
    .sample_hold(sample_hold), .dac_trial(dac_trial), .irq(irq));
  analog_model u_analog (.aclk(aclk), .sample_hold(sample_hold), .dac_trial(dac_trial),
    .vin(vin), .cmp_in(cmp_in));
  initial begin
    forever #4 aclk = ~aclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] exp_res(input logic [9:0] x, input logic hi);
    return hi ? {24'h0, x[9:2]} : {30'h0, x[1:0]};
  endfunction
  function automatic logic [1:0] exp_resp(input logic [7:0] a);
    return (a > IRQ_ENABLE_OFFS || a[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    x = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic rck(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    logic [1:0] rs;
    rd(a, x, rs);
    chk(nm, e, x);
    chk("rresp", {30'h0, exp_resp(a)}, {30'h0, rs});
  endtask
  // A hang in a handshake or a conversion ends the run here.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ***
  // Main sequence
  // ***
  initial begin
    seed = 32'hA0E4764F;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rck("ctrl", CTRL_OFFS, ZERO_WORD);
    rck("stat", IRQ_STATUS_OFFS, ZERO_WORD);
    rck("clrreg", IRQ_CLEAR_OFFS, ZERO_WORD);
    rck("unmapped", 8'h18, ZERO_WORD);
    wr(8'h18, 32'h1, r);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(CTRL_OFFS, 32'h8, r);
    rck("nostart", CTRL_OFFS, ZERO_WORD);
    $display("test reset done");
    wr(CTRL_OFFS, 32'h1, r);
    rck("early", CTRL_OFFS, 32'h1);
    repeat (SETUP_CYCLES) @(posedge aclk);
    rck("setup", CTRL_OFFS, 32'h21);
    // A write with lane 0 masked must leave the control bits untouched.
    wstrb <= 4'hE;
    wr(CTRL_OFFS, ZERO_WORD, r);
    wstrb <= 4'hF;
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    rck("lane", CTRL_OFFS, 32'h21);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : 10'(xs());
      vin <= v;
      wr(IRQ_ENABLE_OFFS, {31'h0, i != 0}, r);
      t0 = cyc;
      wr(CTRL_OFFS, 32'h9, r);
      rck("busy", CTRL_OFFS, 32'h29);
      wr(CTRL_OFFS, 32'h9, r);
      do rd(CTRL_OFFS, d, r); while (d[CTRL_START_BIT] === 1'b1);
      chk("done", 32'h31, d);
      chk("trial", {22'h0, v}, {22'h0, dac_trial});
      chk("sh", ZERO_WORD, {31'h0, sample_hold});
      chk("tconv", 32'h1, {31'h0, (cyc - t0) inside {[1958:2170]}});
      rck("high", RES_HIGH_OFFS, exp_res(v, 1'b1));
      rck("low", RES_LOW_OFFS, exp_res(v, 1'b0));
      chk("mask", {31'h0, i != 0}, {31'h0, irq});
      wr(IRQ_ENABLE_OFFS, 32'h1, r);
      repeat (300) @(posedge aclk);
      chk("irq", 32'h1, {31'h0, irq});
      rck("sticky", IRQ_STATUS_OFFS, 32'h1);
      wr(IRQ_CLEAR_OFFS, 32'h1, r);
      rck("clear", IRQ_STATUS_OFFS, ZERO_WORD);
      chk("irq0", ZERO_WORD, {31'h0, irq});
      $display("test conv %0d done", i);
    end
    report_and_stop();
  end
endmodule // adc_conversion_sequencer_bench
